// file: logic/i2csr_consts.svh
/*
  Register offsets, field positions, reset values and status codes of the
  two-wire slave receiver. Assumes it is included by the design and bench files.
*/
`ifndef I2CSR_CONSTS_SVH
`define I2CSR_CONSTS_SVH

// Register offsets on the plain register port.
`define I2CSR_ADDR_W        3
`define I2CSR_OFS_CTRL      3'h0
`define I2CSR_OFS_CODE      3'h1
`define I2CSR_OFS_BUF       3'h2
`define I2CSR_OFS_OWN       3'h3
`define I2CSR_OFS_RATE      3'h4
`define I2CSR_OFS_IRQ_STAT  3'h5
`define I2CSR_OFS_IRQ_MASK  3'h6

// Control register field positions.
`define I2CSR_CTRL_FLAG     7
`define I2CSR_CTRL_ACK      6
`define I2CSR_CTRL_BEGIN    5
`define I2CSR_CTRL_HALT     4
`define I2CSR_CTRL_EN       2

// Own address register: address in bits 7..1, broadcast accept in bit 0.
`define I2CSR_OWN_BCAST     0

// Status codes.
`define I2CSR_CODE_SLA_ACK  8'h60
`define I2CSR_CODE_GC_ACK   8'h70
`define I2CSR_CODE_DAT_ACK  8'h80
`define I2CSR_CODE_DAT_NACK 8'h88
`define I2CSR_CODE_GC_DACK  8'h90
`define I2CSR_CODE_GC_NACK  8'h98
`define I2CSR_CODE_END      8'ha0
`define I2CSR_CODE_NONE     8'hf8

// Reset values.
`define I2CSR_RST_BYTE      8'h00
`define I2CSR_RST_RATE      8'h10

// Interrupt event bits.
`define I2CSR_EV_W          3
`define I2CSR_EV_STEP       0
`define I2CSR_EV_STOP       1
`define I2CSR_EV_BEGIN      2

`endif

// file: logic/i2csr_irq.sv
/*
  Sticky interrupt status with write-one-to-clear, a mask and one level
  interrupt. Assumes events are one-cycle pulses on ref_clk.
*/
`timescale 1ns/100ps
`include "i2csr_consts.svh"
module i2csr_irq #(
  parameter int W = `I2CSR_EV_W
) (
  // Clock and reset.
  input  wire logic         ref_clk,
  input  wire logic         rst,
  // Events and register writes.
  input  wire logic [W-1:0] event_in,
  input  wire logic         wr_status,
  input  wire logic         wr_mask,
  input  wire logic [W-1:0] wdata,
  // Register contents and the interrupt line.
  output logic      [W-1:0] status,
  output logic      [W-1:0] mask,
  output logic              irq
);

  typedef struct packed {
    logic [W-1:0] status;
    logic [W-1:0] mask;
    logic         irq;
  } i2csr_irq_t;

  i2csr_irq_t r_reg;
  i2csr_irq_t r_next;

  // An event in the cycle of its clear keeps the bit set.
  always_comb begin
    r_next = r_reg;
    if (wr_status) begin
      r_next.status = r_reg.status & ~wdata;
    end
    r_next.status = r_next.status | event_in;
    if (wr_mask) begin
      r_next.mask = wdata;
    end
    r_next.irq = |(r_next.status & r_next.mask);
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign status = r_reg.status;
  assign mask   = r_reg.mask;
  assign irq    = r_reg.irq;

endmodule // i2csr_irq

// file: logic/i2csr_pkg.sv
/*
  Types of the two-wire slave receiver: controller states and the packed
  state record of the principal module. Assumes nothing of its users.
*/
package i2csr_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_DATA,
    ST_DATA_ACK,
    ST_WAIT,
    ST_WAIT_END,
    ST_GEN
  } i2csr_state_t;

  typedef struct packed {
    i2csr_state_t st;
    logic         flag;
    logic         ack_en;
    logic         begin_req;
    logic         halt_req;
    logic         iface_en;
    logic         bcast;
    logic         ack_next;
    logic [7:0]   code;
    logic [7:0]   data;
    logic [7:0]   shift;
    logic [3:0]   bitcnt;
    logic [7:0]   own_addr;
    logic [7:0]   bitrate;
    logic [7:0]   rdata;
    logic         scl_q;
    logic         sda_q;
    logic         scl_oe;
    logic         sda_oe;
    logic         pin_low;
    logic         busy;
    logic         restart;
    logic         begin_pend;
    logic [7:0]   hold_cnt;
  } i2csr_core_t;

endpackage

// file: logic/i2csr_sync.sv
/*
  Two flip-flop synchroniser for levels entering from outside ref_clk.
  Assumes the input is a level; the reset value models an idle high line.
*/
`timescale 1ns/100ps
module i2csr_sync #(
  parameter int         WIDTH = 1,
  parameter logic [0:0] RST_V = 1'b1
) (
  // Clock and reset.
  input  wire logic             ref_clk,
  input  wire logic             rst,
  // Asynchronous level in, synchronised level out.
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } i2csr_sync_t;

  i2csr_sync_t r_reg;
  i2csr_sync_t r_next;

  // The first stage feeds only the second one.
  always_comb begin
    r_next.s1 = async_in;
    r_next.s2 = r_reg.s1;
  end

  // Both stages reset to the idle level.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      r_reg <= {(2 * WIDTH){RST_V}};
    end else begin
      r_reg <= r_next;
    end
  end

  assign sync_out = r_reg.s2;

endmodule // i2csr_sync

// file: logic/i2csr_top.sv
/*
  Slave receiver of a byte-oriented two-wire serial interface: address match,
  byte reception with ACK or NOT ACK, status codes, clock stretching while
  software answers, and a queued START when the bus is free.
  Assumes an external master drives the bus clock; the pins are open drain
  and resolved outside; software uses the plain register port on ref_clk.
*/
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/100ps
`include "i2csr_consts.svh"
module i2csr_top (
  // Clock and reset.
  input  wire logic                     ref_clk,
  input  wire logic                     rst,
  // Register port.
  input  wire logic [`I2CSR_ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]               reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic      [7:0]               reg_rdata,
  // Bus clock pin.
  input  wire logic                     scl_in,
  output logic                          scl_out,
  output logic                          scl_oe,
  // Bus data pin.
  input  wire logic                     sda_in,
  output logic                          sda_out,
  output logic                          sda_oe,
  // Interrupt.
  output logic                          irq
);

  i2csr_pkg::i2csr_core_t r_reg;
  i2csr_pkg::i2csr_core_t r_next;

  logic                     scl_s;
  logic                     sda_s;
  logic [`I2CSR_EV_W-1:0]   ev;
  logic [`I2CSR_EV_W-1:0]   irq_status;
  logic [`I2CSR_EV_W-1:0]   irq_mask;
  logic                     irq_wr_status;
  logic                     irq_wr_mask;

  // Both pins are foreign to ref_clk and pass two flip-flops first.
  i2csr_sync #(.WIDTH(1), .RST_V(1'b1)) u_sync_scl (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .async_in (scl_in),
    .sync_out (scl_s)
  );

  i2csr_sync #(.WIDTH(1), .RST_V(1'b1)) u_sync_sda (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .async_in (sda_in),
    .sync_out (sda_s)
  );

  // Interrupt status and mask writes are decoded here.
  assign irq_wr_status = reg_wr && (reg_addr == `I2CSR_OFS_IRQ_STAT);
  assign irq_wr_mask   = reg_wr && (reg_addr == `I2CSR_OFS_IRQ_MASK);

  i2csr_irq #(.W(`I2CSR_EV_W)) u_irq (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .event_in  (ev),
    .wr_status (irq_wr_status),
    .wr_mask   (irq_wr_mask),
    .wdata     (reg_wdata[`I2CSR_EV_W-1:0]),
    .status    (irq_status),
    .mask      (irq_mask),
    .irq       (irq)
  );

  // Bus conditions, register access and the receive controller.
  always_comb begin
    logic rise;
    logic fall;
    logic start_c;
    logic stop_c;
    logic resume;
    logic own_hit;
    logic gc_hit;
    rise    = 1'b0;
    fall    = 1'b0;
    start_c = 1'b0;
    stop_c  = 1'b0;
    resume  = 1'b0;
    own_hit = 1'b0;
    gc_hit  = 1'b0;
    r_next  = r_reg;
    ev      = '0;

    // Edges and conditions are judged on synchronised samples only.
    rise    = scl_s && !r_reg.scl_q;
    fall    = !scl_s && r_reg.scl_q;
    start_c = scl_s && r_reg.scl_q && r_reg.sda_q && !sda_s;
    stop_c  = scl_s && r_reg.scl_q && !r_reg.sda_q && sda_s;
    r_next.scl_q   = scl_s;
    r_next.sda_q   = sda_s;
    r_next.pin_low = 1'b0;
    if (start_c) begin
      r_next.busy = 1'b1;
    end
    if (stop_c) begin
      r_next.busy = 1'b0;
      ev[`I2CSR_EV_STOP] = 1'b1;
    end

    // Register writes; writing one to the flag is the software reply.
    if (reg_wr) begin
      unique case (reg_addr)
        `I2CSR_OFS_CTRL: begin
          r_next.ack_en    = reg_wdata[`I2CSR_CTRL_ACK];
          r_next.begin_req = reg_wdata[`I2CSR_CTRL_BEGIN];
          r_next.halt_req  = reg_wdata[`I2CSR_CTRL_HALT];
          r_next.iface_en  = reg_wdata[`I2CSR_CTRL_EN];
          resume = reg_wdata[`I2CSR_CTRL_FLAG] && r_reg.flag;
        end
        `I2CSR_OFS_BUF:  r_next.data     = reg_wdata;
        `I2CSR_OFS_OWN:  r_next.own_addr = reg_wdata;
        `I2CSR_OFS_RATE: r_next.bitrate  = reg_wdata;
        default: ;
      endcase
    end

    // Read data stands in the cycle after the strobe; unmapped reads zero.
    if (reg_rd) begin
      unique case (reg_addr)
        `I2CSR_OFS_CTRL: r_next.rdata = {r_reg.flag, r_reg.ack_en, r_reg.begin_req,
                                         r_reg.halt_req, 1'b0, r_reg.iface_en, 2'b00};
        `I2CSR_OFS_CODE: r_next.rdata = r_reg.code;
        `I2CSR_OFS_BUF:  r_next.rdata = r_reg.data;
        `I2CSR_OFS_OWN:  r_next.rdata = r_reg.own_addr;
        `I2CSR_OFS_RATE: r_next.rdata = r_reg.bitrate;
        `I2CSR_OFS_IRQ_STAT: r_next.rdata = {{(8-`I2CSR_EV_W){1'b0}}, irq_status};
        `I2CSR_OFS_IRQ_MASK: r_next.rdata = {{(8-`I2CSR_EV_W){1'b0}}, irq_mask};
        default: r_next.rdata = 8'h00;
      endcase
    end

    // Address matches; recognition follows ack enable at all times.
    own_hit = (r_reg.shift[7:1] == r_reg.own_addr[7:1]) && !r_reg.shift[0]
              && r_reg.ack_en;
    gc_hit  = (r_reg.shift[7:1] == 7'h00) && !r_reg.shift[0] && r_reg.ack_en
              && r_reg.own_addr[`I2CSR_OWN_BCAST];

    if (!r_next.iface_en) begin
      // Disabled, or being disabled by this write: let go of both lines at once,
      // so a stretched clock is never held a cycle past the disabling write.
      r_next.st     = i2csr_pkg::ST_IDLE;
      r_next.flag   = 1'b0;
      r_next.scl_oe = 1'b0;
      r_next.sda_oe = 1'b0;
      r_next.code   = `I2CSR_CODE_NONE;
    end else begin
      unique case (r_reg.st)
        i2csr_pkg::ST_IDLE: begin
          if (start_c) begin
            r_next.st     = i2csr_pkg::ST_ADDR;
            r_next.bitcnt = 4'h0;
          end else if (r_reg.begin_pend && !r_reg.busy && !r_reg.flag) begin
            // Queued START: pull data low while the clock is high.
            r_next.st       = i2csr_pkg::ST_GEN;
            r_next.sda_oe   = 1'b1;
            r_next.hold_cnt = r_reg.bitrate;
          end
        end

        i2csr_pkg::ST_GEN: begin
          // Own START is not fed back as a new frame while the bit rate is 2 or more; at 0 or 1 it is detected in ST_IDLE and enters ST_ADDR.
          if (r_reg.hold_cnt == 8'h00) begin
            r_next.st         = i2csr_pkg::ST_IDLE;
            r_next.sda_oe     = 1'b0;
            r_next.begin_pend = 1'b0;
            ev[`I2CSR_EV_BEGIN] = 1'b1;
          end else begin
            r_next.hold_cnt = r_reg.hold_cnt - 8'h01;
          end
        end

        i2csr_pkg::ST_ADDR: begin
          if (start_c) begin
            r_next.bitcnt = 4'h0;
          end else if (stop_c) begin
            r_next.st = i2csr_pkg::ST_IDLE;
          end else if (rise) begin
            r_next.shift  = {r_reg.shift[6:0], sda_s};
            r_next.bitcnt = r_reg.bitcnt + 4'h1;
          end else if (fall && r_reg.bitcnt == 4'h8) begin
            if (own_hit || gc_hit) begin
              r_next.st     = i2csr_pkg::ST_ADDR_ACK;
              r_next.sda_oe = 1'b1;
              r_next.bcast  = gc_hit && !own_hit;
            end else begin
              r_next.st = i2csr_pkg::ST_IDLE;
            end
          end
        end

        i2csr_pkg::ST_ADDR_ACK: begin
          // End of the acknowledge clock: report and stretch.
          if (fall) begin
            r_next.st     = i2csr_pkg::ST_WAIT;
            r_next.sda_oe = 1'b0;
            r_next.flag   = 1'b1;
            r_next.scl_oe = 1'b1;
            r_next.code   = r_reg.bcast ? `I2CSR_CODE_GC_ACK
                                        : `I2CSR_CODE_SLA_ACK;
            ev[`I2CSR_EV_STEP] = 1'b1;
          end
        end

        i2csr_pkg::ST_DATA: begin
          if (start_c || stop_c) begin
            // Frame ended under us while addressed.
            r_next.st      = i2csr_pkg::ST_WAIT_END;
            r_next.flag    = 1'b1;
            r_next.scl_oe  = 1'b1;
            r_next.restart = start_c;
            r_next.code    = `I2CSR_CODE_END;
            ev[`I2CSR_EV_STEP] = 1'b1;
          end else if (rise) begin
            r_next.shift  = {r_reg.shift[6:0], sda_s};
            r_next.bitcnt = r_reg.bitcnt + 4'h1;
          end else if (fall && r_reg.bitcnt == 4'h8) begin
            r_next.st     = i2csr_pkg::ST_DATA_ACK;
            r_next.data   = r_reg.shift;
            r_next.sda_oe = r_reg.ack_next;
          end
        end

        i2csr_pkg::ST_DATA_ACK: begin
          if (fall) begin
            r_next.sda_oe  = 1'b0;
            r_next.restart = 1'b0;  // A restart seen in an earlier frame must not apply here.
            r_next.flag    = 1'b1;
            r_next.scl_oe  = 1'b1;
            r_next.st     = r_reg.ack_next ? i2csr_pkg::ST_WAIT : i2csr_pkg::ST_WAIT_END;
            ev[`I2CSR_EV_STEP] = 1'b1;
            if (r_reg.bcast) begin
              r_next.code = r_reg.ack_next ? `I2CSR_CODE_GC_DACK
                                           : `I2CSR_CODE_GC_NACK;
            end else begin
              r_next.code = r_reg.ack_next ? `I2CSR_CODE_DAT_ACK
                                           : `I2CSR_CODE_DAT_NACK;
            end
          end
        end

        i2csr_pkg::ST_WAIT: begin
          // Still addressed: the reply picks ACK or NOT ACK for the next byte.
          if (resume) begin
            r_next.st       = i2csr_pkg::ST_DATA;
            r_next.flag     = 1'b0;
            r_next.scl_oe   = 1'b0;
            r_next.bitcnt   = 4'h0;
            r_next.ack_next = reg_wdata[`I2CSR_CTRL_ACK];
          end
        end

        i2csr_pkg::ST_WAIT_END: begin
          // Leaving the addressed state; a restart resumes address capture when the reply sets ACK.
          if (resume) begin
            r_next.flag       = 1'b0;
            r_next.scl_oe     = 1'b0;
            r_next.bcast      = 1'b0;
            r_next.restart    = 1'b0;
            r_next.bitcnt     = 4'h0;
            r_next.begin_pend = reg_wdata[`I2CSR_CTRL_BEGIN];
            r_next.st = (r_reg.restart && reg_wdata[`I2CSR_CTRL_ACK])
                        ? i2csr_pkg::ST_ADDR : i2csr_pkg::ST_IDLE;
          end
        end

        default: r_next.st = i2csr_pkg::ST_IDLE;
      endcase
    end
  end

  // All state in one record; reset leaves the bus released and idle.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      r_reg          <= '0;
      r_reg.st       <= i2csr_pkg::ST_IDLE;
      r_reg.code     <= `I2CSR_CODE_NONE;
      r_reg.data     <= `I2CSR_RST_BYTE;
      r_reg.bitrate  <= `I2CSR_RST_RATE;
      r_reg.scl_q    <= 1'b1;
      r_reg.sda_q    <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs come straight from the record; pins only ever pull low.
  assign reg_rdata = r_reg.rdata;
  assign scl_out   = r_reg.pin_low;
  assign sda_out   = r_reg.pin_low;
  assign scl_oe    = r_reg.scl_oe;
  assign sda_oe    = r_reg.sda_oe;

endmodule // i2csr_top

// file: testbench/i2csr_master.sv
/*
  Behavioural bus master that addresses the slave receiver at 80 ns per bit.
  Assumes the bench resolves both lines with pull-ups from every pull.
*/
`timescale 1ns/100ps
module i2csr_master (
  // Resolved wire levels.
  input  wire logic scl_w,
  input  wire logic sda_w,
  // Pulls toward ground and a stall flag.
  output logic      scl_low,
  output logic      sda_low,
  output logic      hang
);
  // Both lines start released, so the bus idles high.
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    hang    = 1'b0;
  end
  // Release the clock and honour stretching, but a stuck clock raises hang.
  task automatic rise();
    int n;
    n = 0;
    scl_low = 1'b0;
    #1;
    while (scl_w !== 1'b1 && n < 20000) begin
      #8;
      n++;
    end
    if (n == 20000) begin
      hang = 1'b1;
    end
    #39;
  endtask
  // Data falls while the clock is high.
  task automatic start();
    sda_low = 1'b1;
    #40;
    scl_low = 1'b1;
    #20;
  endtask
  // Data rises while the clock is high; the clock then stands still.
  task automatic stop();
    sda_low = 1'b1;
    #20;
    rise();
    sda_low = 1'b0;
    #40;
  endtask
  // Most significant bit first; data changes only while the clock is low.
  task automatic bits(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      sda_low = ~b[i];
      #20;
      rise();
      scl_low = 1'b1;
      #20;
    end
  endtask
  // Ninth clock: data released, the answer read late in the high phase.
  task automatic ack_bit(output logic a);
    sda_low = 1'b0;
    #20;
    rise();
    a = ~sda_w;
    scl_low = 1'b1;
    #20;
  endtask
endmodule // i2csr_master

// file: testbench/i2csr_top_chk.sv
/*
  Concurrent checks on the ports of the two-wire slave receiver top.
  Assumes one clock, ref_clk, with a synchronous active-high rst; bound to i2csr_top.
*/
`timescale 1ns/100ps
`include "i2csr_consts.svh"
module i2csr_top_chk (
  // Clock and reset.
  input wire logic                     ref_clk,
  input wire logic                     rst,
  // Register port.
  input wire logic [`I2CSR_ADDR_W-1:0] reg_addr,
  input wire logic [7:0]               reg_wdata,
  input wire logic                     reg_wr,
  input wire logic                     reg_rd,
  input wire logic [7:0]               reg_rdata,
  // Bus pins and interrupt.
  input wire logic                     scl_in,
  input wire logic                     scl_out,
  input wire logic                     scl_oe,
  input wire logic                     sda_in,
  input wire logic                     sda_out,
  input wire logic                     sda_oe,
  input wire logic                     irq
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  // A software reply is a control write with the flag bit set.
  sequence ctrl_reply;
    reg_wr && reg_addr == `I2CSR_OFS_CTRL && reg_wdata[`I2CSR_CTRL_FLAG];
  endsequence
  // Bit-rate write, a quiet cycle, then a read of the same register.
  sequence rate_wr_rd;
    (reg_wr && reg_addr == `I2CSR_OFS_RATE) ##1 !reg_wr ##1
      (reg_rd && reg_addr == `I2CSR_OFS_RATE);
  endsequence
  // Mask cleared, then a cycle with no further mask write.
  sequence mask_off;
    (reg_wr && reg_addr == `I2CSR_OFS_IRQ_MASK && reg_wdata[2:0] == 3'h0) ##1
      !(reg_wr && reg_addr == `I2CSR_OFS_IRQ_MASK);
  endsequence

  open_drain_a:
    assert property (!scl_out && !sda_out) else $error("bus pin driven high");
  stretch_hold_a:
    assert property (scl_oe && !(reg_wr && reg_addr == `I2CSR_OFS_CTRL &&
      (reg_wdata[`I2CSR_CTRL_FLAG] || !reg_wdata[`I2CSR_CTRL_EN])) |=> scl_oe)
    else $error("bus clock released without a reply");
  stretch_release_a:
    assert property (scl_oe ##0 ctrl_reply |=> !scl_oe [*2])
    else $error("bus clock still held after a reply");
  code_valid_a:
    assert property (scl_oe && reg_rd && reg_addr == `I2CSR_OFS_CODE |=> reg_rdata inside
      {8'h60, 8'h70, 8'h80, 8'h88, 8'h90, 8'h98, 8'ha0})
    else $error("status code outside the receiver set");
  read_hold_a:
    assert property (!$past(reg_rd) |-> $stable(reg_rdata)) else $error("read data moved");
  unmapped_read_a:
    assert property (reg_rd && reg_addr == 3'h7 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  rate_readback_a:
    assert property (rate_wr_rd |=> reg_rdata == $past(reg_wdata, 3))
    else $error("bit rate read back wrong");
  irq_masked_a:
    assert property (mask_off |=> !irq) else $error("interrupt high with mask clear");
endmodule // i2csr_top_chk

bind i2csr_top i2csr_top_chk u_chk (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));

// file: testbench/i2csr_top_tb.sv
/*
  Self-checking bench: register tasks, a bus master model and receiver scenarios.
  Assumes the design files and the checker are compiled before this file.
*/
`timescale 1ns/100ps
`include "i2csr_consts.svh"
module i2csr_top_tb;
  logic                     ref_clk;
  logic                     rst;
  logic [`I2CSR_ADDR_W-1:0] reg_addr;
  logic [7:0]               reg_wdata;
  logic                     reg_wr;
  logic                     reg_rd;
  logic [7:0]               reg_rdata;
  logic                     scl_out, scl_oe, sda_out, sda_oe, irq;
  logic                     m_scl_low, m_sda_low, m_hang;
  logic                     scl_w, sda_w;
  logic [7:0]               v;
  logic                     a;
  int                       failures = 0;
  int                       cmp_count = 0;
  int                       n, k;

  // Open-drain wires with pull-ups: low while any party pulls.
  assign scl_w = ~(scl_oe | m_scl_low);
  assign sda_w = ~(sda_oe | m_sda_low);

  i2csr_top DUT (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_in(scl_w),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out),
    .sda_oe(sda_oe), .irq(irq));
  i2csr_master u_master (.scl_w(scl_w), .sda_w(sda_w), .scl_low(m_scl_low),
    .sda_low(m_sda_low), .hang(m_hang));

  // 125 MHz clock.
  always #4 ref_clk = ~ref_clk;

  // A stuck bus clock ends the run as a failure.
  always @(posedge m_hang) begin
    failures++;
    close_out();
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // One-cycle write strobe; lowered at the edge that takes it.
  task automatic wr(input logic [`I2CSR_ADDR_W-1:0] ad, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= ad;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stands from the cycle after the strobe until the next read; it is taken in that first cycle.
  task automatic rd(input logic [`I2CSR_ADDR_W-1:0] ad, output logic [7:0] d);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= ad;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // Wait for the step interrupt, check the held state, then reply.
  task automatic step(input logic [7:0] code, input logic [7:0] bx, input logic [7:0] rep);
    int t;
    t = 0;
    while (irq !== 1'b1 && t < 20000) begin
      @(posedge ref_clk);
      #1;
      t++;
    end
    if (t == 20000) begin
      failures++;
      close_out();
    end
    check("clock stretch", {7'h00, scl_oe}, 8'h01);
    rd(`I2CSR_OFS_CODE, v);
    check("status code", v, code);
    if (code inside {8'h80, 8'h88, 8'h90, 8'h98}) begin
      rd(`I2CSR_OFS_BUF, v);
      check("byte buffer", v, bx);
    end
    rd(`I2CSR_OFS_CODE, v);
    check("code held", v, code);
    wr(`I2CSR_OFS_IRQ_STAT, 8'h01);
    wr(`I2CSR_OFS_CTRL, rep);
  endtask

  // Main sequence: reset, setup, then the receiver scenarios.
  initial begin
    ref_clk   = 1'b0;
    rst       = 1'b1;
    reg_addr  = '0;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    rd(`I2CSR_OFS_CODE, v);
    check("idle code", v, `I2CSR_CODE_NONE);
    rd(`I2CSR_OFS_RATE, v);
    check("rate reset", v, `I2CSR_RST_RATE);
    wr(3'h7, 8'h5a);
    rd(3'h7, v);
    check("unmapped read", v, 8'h00);
    wr(`I2CSR_OFS_OWN, 8'ha5);
    wr(`I2CSR_OFS_RATE, 8'h08);
    rd(`I2CSR_OFS_RATE, v);
    check("bit rate", v, 8'h08);
    wr(`I2CSR_OFS_IRQ_MASK, 8'h05);
    wr(`I2CSR_OFS_CTRL, 8'hc4);
    $display("Test setup done");
    // Own address: ACK, ACKed byte, then a NOT ACK byte and leave.
    u_master.start();
    u_master.bits(8'ha4);
    u_master.ack_bit(a);
    check("address ack", {7'h00, a}, 8'h01);
    step(`I2CSR_CODE_SLA_ACK, 8'h00, 8'hc4);
    check("irq cleared", {7'h00, irq}, 8'h00);
    u_master.bits(8'h3c);
    u_master.ack_bit(a);
    check("data ack", {7'h00, a}, 8'h01);
    step(`I2CSR_CODE_DAT_ACK, 8'h3c, 8'h84);
    u_master.bits(8'h5a);
    u_master.ack_bit(a);
    check("data nack", {7'h00, a}, 8'h00);
    step(`I2CSR_CODE_DAT_NACK, 8'h5a, 8'hc4);
    u_master.stop();
    rd(`I2CSR_OFS_IRQ_STAT, v);
    check("masked stop event", {4'h0, v[2:0], irq}, 8'h04);
    wr(`I2CSR_OFS_IRQ_STAT, 8'h02);
    $display("Test own_address done");
    // Broadcast: still recognised after leaving with ack enable set.
    u_master.start();
    u_master.bits(8'h00);
    u_master.ack_bit(a);
    step(`I2CSR_CODE_GC_ACK, 8'h00, 8'hc4);
    u_master.bits(8'h11);
    u_master.ack_bit(a);
    check("broadcast ack", {7'h00, a}, 8'h01);
    step(`I2CSR_CODE_GC_DACK, 8'h11, 8'h84);
    u_master.bits(8'h22);
    u_master.ack_bit(a);
    check("broadcast nack", {7'h00, a}, 8'h00);
    step(`I2CSR_CODE_GC_NACK, 8'h22, 8'h84);
    u_master.stop();
    u_master.start();
    u_master.bits(8'ha4);
    u_master.ack_bit(a);
    check("address ignored", {5'h00, a, irq, scl_oe}, 8'h00);
    u_master.stop();
    wr(`I2CSR_OFS_IRQ_STAT, 8'h02);
    $display("Test broadcast done");
    // STOP while addressed, then a queued START once the bus is free.
    wr(`I2CSR_OFS_CTRL, 8'h44);
    u_master.start();
    u_master.bits(8'ha4);
    u_master.ack_bit(a);
    step(`I2CSR_CODE_SLA_ACK, 8'h00, 8'hc4);
    u_master.bits(8'h77);
    u_master.ack_bit(a);
    step(`I2CSR_CODE_DAT_ACK, 8'h77, 8'hc4);
    u_master.bits(8'h81);
    u_master.ack_bit(a);
    check("next byte ack", {7'h00, a}, 8'h01);
    step(`I2CSR_CODE_DAT_ACK, 8'h81, 8'hc4);
    u_master.stop();
    step(`I2CSR_CODE_END, 8'h00, 8'he4);
    n = 0;
    while (sda_oe !== 1'b1 && n < 500) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (n == 500) begin
      failures++;
      close_out();
    end
    k = 0;
    while (sda_oe === 1'b1 && k < 500) begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    check("start length", 8'(k), 8'h09);
    rd(`I2CSR_OFS_IRQ_STAT, v);
    check("start event", v, 8'h06);
    check("irq raised", {7'h00, irq}, 8'h01);
    wr(`I2CSR_OFS_IRQ_MASK, 8'h00);
    @(posedge ref_clk);
    #1 check("irq masked", {7'h00, irq}, 8'h00);
    wr(`I2CSR_OFS_IRQ_STAT, 8'h07);
    rd(`I2CSR_OFS_IRQ_STAT, v);
    check("status cleared", v, 8'h00);
    $display("Test stop_and_start done");
    close_out();
  end
endmodule // i2csr_top_tb
